// ### rtl/pms_map.svh
// register offsets, field positions, reset values and timings in ns
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
`define PMS_OFF_CTRL       12'h000
`define PMS_OFF_STATUS     12'h004
`define PMS_OFF_IRQ_STAT   12'h008
`define PMS_OFF_IRQ_MASK   12'h00C
`define PMS_CTRL_RESET     32'h0000_0000
`define PMS_MASK_RESET     32'h0000_0000
`define PMS_CTRL_SLEEP     0
`define PMS_CTRL_STOP      1
`define PMS_CTRL_STANDBY   2
`define PMS_CTRL_LPREG     3
`define PMS_CTRL_DET_EN    4
`define PMS_CTRL_DET_FALL  5
`define PMS_CTRL_DET_RISE  6
`define PMS_CTRL_EXT_SEL   7
`define PMS_CTRL_FAIL_IE   8
`define PMS_IRQ_DET        0
`define PMS_IRQ_CLKFAIL    1
`define PMS_IRQ_WAKE       2
`define PMS_OSC_STABLE_NS  2000
`define PMS_CLK_NS         20
`endif

// ### rtl/pms_pkg.sv
// types shared by the power mode sequencer
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_RUN,
        PMS_SLEEP,
        PMS_STOP,
        PMS_WAKE_WAIT,
        PMS_STANDBY
    } pms_state_t;

    typedef enum logic [1:0] {
        PMS_REG_MAIN,
        PMS_REG_LOW,
        PMS_REG_OFF
    } pms_reg_mode_t;

    typedef enum logic [1:0] {
        PMS_BOOT_FLASH,
        PMS_BOOT_SYSMEM,
        PMS_BOOT_SRAM
    } pms_boot_t;

    // wake sources for stop mode
    typedef struct packed {
        logic [15:0] pin_lines;
        logic        detector;
        logic        rtc_alarm;
        logic        usb_wake;
    } pms_wake_lines_t;

    // domain control outputs
    typedef struct packed {
        logic          cpu_clk_en;
        logic          periph_clk_en;
        logic          core_clk_en;
        logic          pll_en;
        logic          fast_rc_en;
        logic          ext_osc_en;
        logic          core_power_on;
        pms_reg_mode_t reg_mode;
    } pms_domain_t;
endpackage : pms_pkg

// ### rtl/pms_sequencer.sv
// power mode sequencer: run/sleep/stop/standby control with apb registers
// Overview of operation
// - sleep halts cpu only; any event wakes
// - stop gates core clocks, pll, oscillators
// - stop regulator normal or low per software
// - any external interrupt line leaves stop
// - standby switches regulator and core off
// - reset pin, watchdog, wake edge, alarm exit
// - rtc and watchdog keep running in low power
// - regulator main, low power, or off
// - regulator on after reset, off in standby
// - supply below threshold holds device reset
// - detector interrupt on fall, rise or both
// - reset selects internal fast rc clock
// - external clock failure falls back to rc
// - boot pins sampled at startup
//
// The APB slave port and the address map are this design's own decisions.
`include "pms_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pms_sequencer #(
    parameter int OSC_WAIT = (`PMS_OSC_STABLE_NS + `PMS_CLK_NS - 1)
                             / `PMS_CLK_NS
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   supply_ok,
    input  wire logic                   supply_above_det,
    input  wire logic                   external_reset_pin_n,
    input  wire logic                   independent_watchdog_rst,
    input  wire logic                   wake_pin,
    input  wire pms_pkg::pms_wake_lines_t wake_lines,
    input  wire logic                   any_event,
    input  wire logic                   ext_osc_fail,
    input  wire logic                   osc_ready,
    input  wire logic [1:0]             boot_pins,
    output logic                        core_reset_n,
    output pms_pkg::pms_domain_t        domain,
    output logic                        always_on_en,
    output logic                        sys_clk_ext,
    output pms_pkg::pms_boot_t          boot_sel,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // local decode and state
    localparam int WW = $clog2(OSC_WAIT + 1);

    pms_pkg::pms_state_t state_reg;      // power mode
    logic [31:0]         ctrl_reg;       // software control
    logic [2:0]          irq_stat_reg;   // sticky events
    logic [2:0]          irq_mask_reg;   // event enables
    logic [WW-1:0]       wait_reg;       // oscillator settle count
    logic                det_prev_reg;   // detector last level
    logic                wake_prev_reg;  // wake pin last level
    logic                boot_done_reg;  // boot pins captured
    logic                wr_en;          // apb write strobe
    logic                rd_en;          // apb read strobe
    logic                det_fall;       // supply dropped below
    logic                det_rise;       // supply rose above
    logic                det_evt;        // enabled detector event
    logic                clk_fail_evt;   // external clock failure
    logic                stop_wake;      // any stop wake line
    logic                standby_exit;   // any standby exit event
    logic [2:0]          evt;            // events this cycle

    // register address match
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction : hit

    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign pready = 1'b1;  // zero wait-state slave

    ////////////////////////////////////////////////////////////////////////
    // power-down detector reset: a low supply holds the core in reset
    assign core_reset_n = presetn & supply_ok;

    ////////////////////////////////////////////////////////////////////////
    // event detection
    assign det_fall = det_prev_reg & ~supply_above_det;
    assign det_rise = ~det_prev_reg & supply_above_det;
    // detector stays quiet until software enables it
    assign det_evt  = ctrl_reg[`PMS_CTRL_DET_EN] &
                      ((det_fall & ctrl_reg[`PMS_CTRL_DET_FALL]) |
                       (det_rise & ctrl_reg[`PMS_CTRL_DET_RISE]));
    assign clk_fail_evt = ctrl_reg[`PMS_CTRL_EXT_SEL] & ext_osc_fail;
    assign stop_wake = (|wake_lines.pin_lines) | wake_lines.detector |
                       wake_lines.rtc_alarm | wake_lines.usb_wake;
    assign standby_exit = ~external_reset_pin_n |
                          independent_watchdog_rst |
                          (wake_pin & ~wake_prev_reg) |
                          wake_lines.rtc_alarm;
    assign evt = {(state_reg == pms_pkg::PMS_WAKE_WAIT) &&
                  (wait_reg == '0), clk_fail_evt, det_evt};

    // edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            det_prev_reg  <= 1'b1;
            wake_prev_reg <= 1'b0;
        end
        else
        begin
            det_prev_reg  <= supply_above_det;
            wake_prev_reg <= wake_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register; mode request bits self-clear once taken
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `PMS_CTRL_RESET;
        else
        begin
            if (wr_en && hit(paddr, `PMS_OFF_CTRL))
                ctrl_reg <= pwdata;
            // standby powers the core off: control is lost, so the
            // wake-up starts again from the internal rc
            else if (state_reg == pms_pkg::PMS_STANDBY)
                ctrl_reg <= `PMS_CTRL_RESET;
            else if (state_reg != pms_pkg::PMS_RUN)
                ctrl_reg[`PMS_CTRL_STANDBY:`PMS_CTRL_SLEEP] <= 3'b000;
            // clock failure drops back to the internal rc
            if (clk_fail_evt)
                ctrl_reg[`PMS_CTRL_EXT_SEL] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power mode state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= pms_pkg::PMS_RUN;
            wait_reg  <= '0;
        end
        else
        begin
            unique case (state_reg)
                pms_pkg::PMS_RUN:
                begin
                    // standby takes priority over stop, stop over sleep
                    if (ctrl_reg[`PMS_CTRL_STANDBY])
                        state_reg <= pms_pkg::PMS_STANDBY;
                    else if (ctrl_reg[`PMS_CTRL_STOP])
                        state_reg <= pms_pkg::PMS_STOP;
                    else if (ctrl_reg[`PMS_CTRL_SLEEP])
                        state_reg <= pms_pkg::PMS_SLEEP;
                end
                pms_pkg::PMS_SLEEP:
                    if (any_event)
                        state_reg <= pms_pkg::PMS_RUN;
                pms_pkg::PMS_STOP:
                    if (stop_wake)
                    begin
                        state_reg <= pms_pkg::PMS_WAKE_WAIT;
                        wait_reg  <= WW'(OSC_WAIT);
                    end
                pms_pkg::PMS_WAKE_WAIT:
                begin
                    // clocks stay gated until the rc has settled
                    if (wait_reg != '0)
                        wait_reg <= wait_reg - WW'(1);
                    else if (osc_ready)
                        state_reg <= pms_pkg::PMS_RUN;
                end
                pms_pkg::PMS_STANDBY:
                    // exit behaves like a fresh start: back to run
                    if (standby_exit)
                        state_reg <= pms_pkg::PMS_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // domain controls derived from the mode
    always_comb
    begin
        domain = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, core_clk_en: 1'b1,
                   pll_en: 1'b1, fast_rc_en: 1'b1,
                   ext_osc_en: ctrl_reg[`PMS_CTRL_EXT_SEL],
                   core_power_on: 1'b1,
                   reg_mode: pms_pkg::PMS_REG_MAIN};
        unique case (state_reg)
            pms_pkg::PMS_RUN: ;
            pms_pkg::PMS_SLEEP:
                domain.cpu_clk_en = 1'b0;
            pms_pkg::PMS_STOP, pms_pkg::PMS_WAKE_WAIT:
            begin
                domain.cpu_clk_en    = 1'b0;
                domain.periph_clk_en = 1'b0;
                domain.core_clk_en   = 1'b0;
                domain.pll_en        = 1'b0;
                domain.ext_osc_en    = 1'b0;
                domain.fast_rc_en    = (state_reg == pms_pkg::PMS_WAKE_WAIT);
                domain.reg_mode = ctrl_reg[`PMS_CTRL_LPREG] ?
                                  pms_pkg::PMS_REG_LOW :
                                  pms_pkg::PMS_REG_MAIN;
            end
            pms_pkg::PMS_STANDBY:
            begin
                domain = '{default: 1'b0,
                           reg_mode: pms_pkg::PMS_REG_OFF};
            end
        endcase
    end

    // always-on parts never gated by mode
    assign always_on_en = 1'b1;
    assign sys_clk_ext  = ctrl_reg[`PMS_CTRL_EXT_SEL];

    ////////////////////////////////////////////////////////////////////////
    // boot pins captured on the first clock after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot_sel      <= pms_pkg::PMS_BOOT_FLASH;
            boot_done_reg <= 1'b0;
        end
        else if (!boot_done_reg)
        begin
            boot_done_reg <= 1'b1;
            unique case (boot_pins)
                2'b00, 2'b10: boot_sel <= pms_pkg::PMS_BOOT_FLASH;
                2'b01:        boot_sel <= pms_pkg::PMS_BOOT_SYSMEM;
                2'b11:        boot_sel <= pms_pkg::PMS_BOOT_SRAM;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over the read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= 3'b000;
        else if (rd_en && hit(paddr, `PMS_OFF_IRQ_STAT))
            // clear only what the setup cycle handed out, so an event
            // landing between setup and access is not lost
            irq_stat_reg <= (irq_stat_reg & ~prdata[2:0]) | evt;
        else
            irq_stat_reg <= irq_stat_reg | evt;
    end

    // interrupt mask; clock failure enable also lives in control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= 3'(`PMS_MASK_RESET);
        else if (wr_en && hit(paddr, `PMS_OFF_IRQ_MASK))
            irq_mask_reg <= pwdata[2:0];
    end

    assign irq = |(irq_stat_reg & irq_mask_reg &
                   {1'b1, ctrl_reg[`PMS_CTRL_FAIL_IE], 1'b1});

    ////////////////////////////////////////////////////////////////////////
    // read data and error response
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (hit(paddr, `PMS_OFF_CTRL))
                prdata <= ctrl_reg;
            else if (hit(paddr, `PMS_OFF_STATUS))
                prdata <= {27'h000_0000, boot_sel, state_reg};
            else if (hit(paddr, `PMS_OFF_IRQ_STAT))
                prdata <= {29'h0000_0000, irq_stat_reg};
            else if (hit(paddr, `PMS_OFF_IRQ_MASK))
                prdata <= {29'h0000_0000, irq_mask_reg};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // unmapped addresses answer with an error
    assign pslverr = psel & penable &
                     ~(hit(paddr, `PMS_OFF_CTRL) |
                       hit(paddr, `PMS_OFF_STATUS) |
                       hit(paddr, `PMS_OFF_IRQ_STAT) |
                       hit(paddr, `PMS_OFF_IRQ_MASK));

endmodule : pms_sequencer
`default_nettype wire

// ### verification/pms_sequencer_sva.sv
// port assertions for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pms_sva (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     penable,
    input wire logic                     supply_ok,
    input wire logic                     wake_pin,
    input wire pms_pkg::pms_wake_lines_t wake_lines,
    input wire logic                     osc_ready,
    input wire logic                     ext_osc_fail,
    input wire logic                     core_reset_n,
    input wire pms_pkg::pms_domain_t     domain,
    input wire logic                     always_on_en,
    input wire logic                     sys_clk_ext
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    reset_hold_a: assert property (!supply_ok |-> !core_reset_n)
        else $error("reset not held on low supply");
    stop_gate_a: assert property (
        $fell(domain.core_clk_en) && domain.core_power_on
        |-> !(domain.pll_en || domain.fast_rc_en || domain.ext_osc_en))
        else $error("oscillator left on in stop");
    standby_off_a: assert property (
        !domain.core_power_on |-> domain.reg_mode == pms_pkg::PMS_REG_OFF
        && !(domain.pll_en || domain.fast_rc_en || domain.ext_osc_en))
        else $error("standby left power on");
    standby_exit_a: assert property (
        !domain.core_power_on && ($rose(wake_pin) || wake_lines.rtc_alarm)
        |-> ##[1:8] domain.core_power_on)
        else $error("no exit from standby");
    always_on_a: assert property (always_on_en)
        else $error("always-on part stopped");
    reset_dflt_a: assert property (
        $rose(presetn) |-> !sys_clk_ext && domain.fast_rc_en
        && domain.reg_mode == pms_pkg::PMS_REG_MAIN)
        else $error("bad clock or regulator after reset");
    clk_fail_a: assert property (
        sys_clk_ext && ext_osc_fail && !penable |=> !sys_clk_ext)
        else $error("no fallback on clock failure");
    osc_wait_a: assert property (
        $rose(domain.core_clk_en) && $past(domain.core_power_on)
        |-> $past(osc_ready))
        else $error("core clocks before oscillator ready");
    // the three low power entries
    sleep_c: cover property ($fell(domain.cpu_clk_en) && domain.core_clk_en);
    stop_c: cover property ($fell(domain.core_clk_en));
    standby_c: cover property ($fell(domain.core_power_on));
endmodule : pms_sva
bind pms_sequencer pms_sva pms_sva_i (.pclk, .presetn, .penable,
    .supply_ok, .wake_pin, .wake_lines, .osc_ready, .ext_osc_fail,
    .core_reset_n, .domain, .always_on_en, .sys_clk_ext);
`default_nettype wire

// ### verification/pms_far.sv
// far side model: oscillator start-up and boot straps
`timescale 1ns/1ps
`default_nettype none
module pms_far #(
    parameter int OSC_DLY = 2
) (
    input  wire logic       pclk,
    input  wire logic       osc_on,
    input  wire logic [1:0] boot_req,
    output logic            osc_ready,
    output logic [1:0]      boot_pins
);
    int dly = 0; // cycles since the oscillator was enabled, stopping at OSC_DLY
    // ready only after settling, lost at once when switched off
    always @(posedge pclk)
        dly <= osc_on ? ((dly < OSC_DLY) ? dly + 1 : dly) : 0;
    assign osc_ready = osc_on && (dly >= OSC_DLY);
    // straps held at the wanted start-up choice
    assign boot_pins = boot_req;
endmodule : pms_far
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the power mode sequencer
`include "pms_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        supply_ok, supply_above_det, any_event, ext_osc_fail;
    logic        external_reset_pin_n, independent_watchdog_rst, wake_pin;
    logic        osc_ready, core_reset_n, always_on_en, sys_clk_ext, irq;
    logic [1:0]  boot_pins, boot_req;
    logic [1:0]  bt [4] = '{2'h0, 2'h1, 2'h0, 2'h2}; // strap to choice
    logic [18:0] src [4] = '{19'h4_0000, 19'h4, 19'h2, 19'h1};
    logic [7:0]  dc [4] = '{8'h00, 8'h30, 8'h50, 8'h70}; // edge select
    logic [7:0]  de = 8'hE4; // expected event per detector step
    int          bad_count, checks, cyc_n, n;
    pms_pkg::pms_wake_lines_t wake_lines;
    pms_pkg::pms_domain_t     domain;
    pms_pkg::pms_boot_t       boot_sel;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w)
            chk(prdata, x);
        chk(pslverr, e);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, 0, 0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0, x, 0);
    endtask : rd
    task automatic rst(input logic [1:0] b);
        @(posedge pclk);
        {presetn, boot_req} <= {1'b0, b};
        repeat (6) @(posedge pclk);
        presetn <= 1;
    endtask : rst
    // bounded wait for one bit of the domain controls
    task automatic waitbit(input int b);
        n = 0;
        while (domain[b] !== 1'b1 && n < 30)
        begin
            @(negedge pclk);
            n++;
        end
    endtask : waitbit
    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////
    pms_sequencer #(.OSC_WAIT(3)) pms_sequencer_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .supply_ok, .supply_above_det, .external_reset_pin_n,
        .independent_watchdog_rst, .wake_pin, .wake_lines, .any_event,
        .ext_osc_fail, .osc_ready, .boot_pins, .core_reset_n, .domain,
        .always_on_en, .sys_clk_ext, .boot_sel, .irq);
    pms_far pms_far_i (.pclk, .osc_on(domain.fast_rc_en), .boot_req,
        .osc_ready, .boot_pins);
    initial
    begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    // a hang counts as a mismatch
    always @(posedge pclk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000)
        begin
            bad_count++;
            results();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, any_event, ext_osc_fail} = '0;
        {wake_pin, independent_watchdog_rst, paddr, pwdata} = '0;
        {supply_ok, supply_above_det, external_reset_pin_n} = '1;
        {wake_lines, boot_req} = '0;
        // each strap code; a chosen external clock must not survive reset
        for (int i = 0; i < 4; i++)
        begin
            rst(i[1:0]);
            settle(1);
            chk(boot_sel, bt[i]);
            chk(sys_clk_ext, 0);
            rd(`PMS_OFF_STATUS, {27'h0, bt[i], 3'h0});
            wr(`PMS_OFF_CTRL, 32'h0000_0080);
            settle(0);
            chk(sys_clk_ext, 1);
        end
        wr(`PMS_OFF_CTRL, 32'h0000_0000);
        apb(0, 12'h010, 0, 0, 1); // unmapped place answers with an error
        @(posedge pclk);
        supply_ok <= 0;
        settle(0);
        chk(core_reset_n, 0);
        @(posedge pclk);
        supply_ok <= 1;
        wr(`PMS_OFF_CTRL, 32'h0000_0001);
        settle(1);
        chk(domain[8:7], 2'b01);
        @(posedge pclk);
        any_event <= 1;
        waitbit(8);
        chk(domain.cpu_clk_en, 1);
        @(posedge pclk);
        any_event <= 0;
        // stop with each regulator setting and each kind of wake line
        for (int k = 0; k < 4; k++)
        begin
            // the later passes also select the external clock
            wr(`PMS_OFF_CTRL, {24'h0, k[1], 3'h0, k[0], 3'h2});
            settle(1);
            chk(domain[6:3], 4'h0);
            chk(domain.reg_mode, k[0] ? 2'h1 : 2'h0);
            @(posedge pclk);
            wake_lines <= src[k];
            @(posedge pclk);
            wake_lines <= '0;
            waitbit(6);
            chk(n > 2, 1);
            chk(domain.core_clk_en, 1);
            rd(`PMS_OFF_IRQ_STAT, 32'h0000_0004);
        end
        // standby left by each of its four exits
        for (int k = 0; k < 4; k++)
        begin
            // odd passes enter standby with the external clock chosen
            wr(`PMS_OFF_CTRL, {24'h0, k[0], 7'h04});
            settle(1);
            chk(domain[2:0], {1'b0, pms_pkg::PMS_REG_OFF});
            chk(always_on_en, 1);
            @(posedge pclk);
            case (k)
                0: external_reset_pin_n <= 0;
                1: independent_watchdog_rst <= 1;
                2: wake_pin <= 1;
                default: wake_lines.rtc_alarm <= 1;
            endcase
            @(posedge pclk);
            {external_reset_pin_n, independent_watchdog_rst} <= 2'b10;
            {wake_pin, wake_lines} <= '0;
            waitbit(2);
            chk(domain.core_power_on, 1);
            chk(domain.reg_mode, pms_pkg::PMS_REG_MAIN);
            chk(sys_clk_ext, 0);
        end
        // detector off, then falling, rising and both edges
        wr(`PMS_OFF_IRQ_MASK, 32'h0000_0001);
        for (int j = 0; j < 8; j++)
        begin
            wr(`PMS_OFF_CTRL, {24'h0, dc[j/2]});
            @(posedge pclk);
            supply_above_det <= j[0];
            settle(2);
            chk(irq, de[j]);
            rd(`PMS_OFF_IRQ_STAT, {31'h0, de[j]});
        end
        wr(`PMS_OFF_IRQ_MASK, 32'h0000_0002);
        wr(`PMS_OFF_CTRL, 32'h0000_0180);
        @(posedge pclk);
        ext_osc_fail <= 1;
        settle(2);
        chk({sys_clk_ext, irq}, 2'b01);
        @(posedge pclk);
        ext_osc_fail <= 0;
        rd(`PMS_OFF_CTRL, 32'h0000_0100);
        rd(`PMS_OFF_IRQ_STAT, 32'h0000_0002);
        results();
    end
endmodule : testbench
`default_nettype wire
